// ### sto_pkg.sv
package sto_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned FB_CLOSE_MS      = 80;
    localparam int unsigned FB_OPEN_MAX_MS   = 20;
    localparam int unsigned IND_CLEAR_MS     = 10;
    localparam int unsigned IND_SET_MAX_MS   = 30;
    localparam int unsigned STAGE_LEAD_US    = 10;
    localparam int unsigned FB_CLOSE_CYC     = CLK_HZ / 1000 * FB_CLOSE_MS;
    localparam int unsigned FB_OPEN_CYC      = CLK_HZ / 1000 * FB_OPEN_MAX_MS;
    localparam int unsigned IND_CLEAR_CYC    = CLK_HZ / 1000 * IND_CLEAR_MS;
    localparam int unsigned IND_SET_CYC      = CLK_HZ / 1000 * IND_SET_MAX_MS;
    localparam int unsigned STAGE_LEAD_CYC   = (CLK_HZ / 1_000_000) * STAGE_LEAD_US;
    // ---------------------------------------------------------------
    // widths and reset values
    // ---------------------------------------------------------------
    localparam int unsigned CNT_W            = 32;
    localparam int unsigned SPD_W            = 16;
    localparam logic [15:0] SPD_RESET        = 16'h0000;
    // ---------------------------------------------------------------
    // controller register map (word offsets)
    // ---------------------------------------------------------------
    localparam int unsigned ADDR_W           = 4;
    localparam logic [3:0]  REG_CTRL         = 4'h0;
    localparam logic [3:0]  REG_STATUS       = 4'h1;
    localparam logic [3:0]  REG_ADVANCE      = 4'h2;
    localparam int unsigned CTRL_RUN_BIT     = 0;
    localparam int unsigned CTRL_ESTOP_BIT   = 1;
    localparam int unsigned CTRL_DOOR_BIT    = 2;
    localparam int unsigned ST_FAULT_BIT     = 0;
    localparam int unsigned ST_FB_BIT        = 1;
    localparam int unsigned ST_STAGE_BIT     = 2;
    localparam int unsigned ST_RELAY_BIT     = 3;
    localparam int unsigned ST_STOPPED_BIT   = 4;
    localparam int unsigned ST_RUN_BIT       = 5;
endpackage

// ### sto_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sto_if;
    logic controller_enable_input;
    logic power_stage_enable_input;
    logic relay_trigger;
    logic feedback_closed;
    logic sto_indicator;

    modport drive (
        input  controller_enable_input,
        input  power_stage_enable_input,
        input  relay_trigger,
        output feedback_closed,
        output sto_indicator
    );
    modport safety (
        output controller_enable_input,
        output power_stage_enable_input,
        output relay_trigger,
        input  feedback_closed,
        input  sto_indicator
    );
endinterface
`default_nettype wire

// ### sto_timer.sv
`timescale 1ns/100ps
`default_nettype none
// loadable down counter; done pulses one cycle when it reaches zero
module sto_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         busy_reg;
    logic         busy_next;
    logic         done_reg;
    logic         done_next;

    initial begin
        if (W < 2) $error("sto_timer width too small");
    end

    always_comb begin
        cnt_next  = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (load) begin
            // a zero load expires at once so a delay of 0 costs one cycle
            cnt_next  = value;
            busy_next = (value != '0);
            done_next = (value == '0);
        end else if (busy_reg) begin
            cnt_next = cnt_reg - 1'b1;
            if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign busy = busy_reg;
    assign done = done_reg;
endmodule
`default_nettype wire

// ### sto_drive.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - enable rise starts brake release, stage enable
// - brake released only while relay trigger present
// - hold speed zero for programmable start delay
// - ramp up to commanded speed by step
// - enable fall ramps down with quick-stop deceleration
// - hold zero for programmable brake drop-out delay
// - drop internal stage enable after drop-out delay
// - brake applied at ramp end, at latest after ramp plus drop-out time
// - controller removes relay and stage after stage drop
// - feedback contact closes about 80ms after relay off
// - indicator shows within 30ms of contact closing
// - torque-off while running coasts, brake applied
// - controller checks stop request against feedback
// - emergency stop removes both, coast, brake at once
// - door open removes both, blocks restart
// - door without stop request coasts, brake at once
// - external delay at least the deceleration time
// - feedback opens within 20ms, indicator clears 10ms later
// - stage enable leads controller enable by 10us
module sto_drive #(
    parameter int unsigned FB_CLOSE_CYC  = sto_pkg::FB_CLOSE_CYC,
    parameter int unsigned FB_OPEN_CYC   = sto_pkg::FB_OPEN_CYC,
    parameter int unsigned IND_CLEAR_CYC = sto_pkg::IND_CLEAR_CYC,
    parameter int unsigned IND_SET_CYC   = sto_pkg::IND_SET_CYC
) (
    input  wire logic                       clk,
    input  wire logic                       reset,
    sto_if.drive                            link,
    input  wire logic [sto_pkg::CNT_W-1:0]  start_delay_cyc,
    input  wire logic [sto_pkg::CNT_W-1:0]  dropout_delay_cyc,
    input  wire logic [sto_pkg::CNT_W-1:0]  decel_time_cyc,
    input  wire logic [sto_pkg::SPD_W-1:0]  speed_command,
    input  wire logic [sto_pkg::SPD_W-1:0]  accel_step,
    input  wire logic [sto_pkg::SPD_W-1:0]  decel_step,
    output logic [sto_pkg::SPD_W-1:0]       speed_setpoint,
    output logic                            stage_enable,
    output logic                            brake_release
);
    typedef enum logic [2:0] {ST_OFF, ST_HOLD, ST_RUN, ST_DECEL, ST_DROPOUT} sto_state_t;
    localparam int unsigned W = sto_pkg::CNT_W;
    localparam int unsigned S = sto_pkg::SPD_W;

    initial begin
        if (FB_CLOSE_CYC < IND_SET_CYC || FB_OPEN_CYC <= IND_CLEAR_CYC)
            $error("sto_drive timing parameters inconsistent");
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic       en_d_reg;
    assign sync_next = meta_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
            en_d_reg <= 1'b0;
        end else begin
            meta_reg <= {link.relay_trigger, link.power_stage_enable_input,
                         link.controller_enable_input};
            sync_reg <= sync_next;
            en_d_reg <= sync_reg[0];
        end
    end

    logic ctl_en;
    logic stg_en;
    logic relay;
    logic en_rise;
    assign ctl_en  = sync_reg[0];
    assign stg_en  = sync_reg[1];
    assign relay   = sync_reg[2];
    assign en_rise = ctl_en & ~en_d_reg;

    // ---------------------------------------------------------------
    // motion sequencer
    // ---------------------------------------------------------------
    sto_state_t   state_reg;
    sto_state_t   state_next;
    logic [S-1:0] spd_reg;
    logic [S-1:0] spd_next;
    logic         stage_reg;
    logic         stage_next;
    logic         brake_reg;
    logic         brake_next;
    logic         seq_load;
    logic [W-1:0] seq_value;
    logic         seq_done;
    logic         lim_load;
    logic         lim_done;
    logic         lim_busy;
    logic         lim_hit_reg;
    logic         lim_hit_next;
    logic         torque_off;
    logic [S:0]   spd_up;

    // either shut-down path removes torque at once
    assign torque_off = ~stg_en | ~relay;
    assign spd_up     = {1'b0, spd_reg} + {1'b0, accel_step};

    sto_timer #(.W(W)) u_seq (
        .clk   (clk),
        .reset (reset),
        .load  (seq_load),
        .value (seq_value),
        .busy  (),
        .done  (seq_done)
    );

    // brake deadline: ramp time plus drop-out time from enable fall
    sto_timer #(.W(W)) u_lim (
        .clk   (clk),
        .reset (reset),
        .load  (lim_load),
        .value (W'(decel_time_cyc + dropout_delay_cyc)),
        .busy  (lim_busy),
        .done  (lim_done)
    );

    always_comb begin
        state_next   = state_reg;
        spd_next     = spd_reg;
        stage_next   = stage_reg;
        brake_next   = brake_reg & relay;
        seq_load     = 1'b0;
        seq_value    = start_delay_cyc;
        lim_load     = 1'b0;
        lim_hit_next = lim_hit_reg | lim_done;
        case (state_reg)
            ST_OFF: begin
                spd_next   = '0;
                stage_next = 1'b0;
                brake_next = 1'b0;
                if (en_rise && !torque_off) begin
                    state_next = ST_HOLD;
                    stage_next = 1'b1;
                    brake_next = relay;
                    seq_load   = 1'b1;
                end
            end
            ST_HOLD: begin
                spd_next = '0;
                if (seq_done) state_next = ST_RUN;
            end
            ST_RUN: begin
                if (spd_reg < speed_command) begin
                    spd_next = (spd_up > {1'b0, speed_command}) ? speed_command
                                                                : spd_up[S-1:0];
                end else begin
                    spd_next = speed_command;
                end
            end
            ST_DECEL: begin
                spd_next = (spd_reg > decel_step) ? spd_reg - decel_step : '0;
                if (spd_reg <= decel_step) begin
                    state_next = ST_DROPOUT;
                    seq_load   = 1'b1;
                    seq_value  = dropout_delay_cyc;
                end
            end
            ST_DROPOUT: begin
                spd_next   = '0;
                brake_next = 1'b0;
                if (seq_done) begin
                    state_next = ST_OFF;
                    stage_next = 1'b0;
                end
            end
            default: state_next = ST_OFF;
        endcase
        if (!ctl_en && (state_reg == ST_HOLD || state_reg == ST_RUN)) begin
            state_next   = ST_DECEL;
            lim_load     = 1'b1;
            lim_hit_next = 1'b0;
        end
        // the deadline flag outlives the stop, so it only counts while stopping
        if (lim_hit_reg && !lim_busy && (state_reg == ST_DECEL || state_reg == ST_DROPOUT))
            brake_next = 1'b0;
        if (torque_off) begin
            state_next = ST_OFF;
            spd_next   = '0;
            stage_next = 1'b0;
            brake_next = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg   <= ST_OFF;
            spd_reg     <= sto_pkg::SPD_RESET;
            stage_reg   <= 1'b0;
            brake_reg   <= 1'b0;
            lim_hit_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            spd_reg     <= spd_next;
            stage_reg   <= stage_next;
            brake_reg   <= brake_next;
            lim_hit_reg <= lim_hit_next;
        end
    end

    // ---------------------------------------------------------------
    // driver supply model: feedback contact and indicator
    // ---------------------------------------------------------------
    logic [W-1:0] fb_cnt_reg;
    logic [W-1:0] fb_cnt_next;
    logic         fb_reg;
    logic         fb_next;
    logic [W-1:0] ind_cnt_reg;
    logic [W-1:0] ind_cnt_next;
    logic         ind_reg;
    logic         ind_next;

    always_comb begin
        fb_cnt_next  = fb_cnt_reg;
        fb_next      = fb_reg;
        ind_cnt_next = ind_cnt_reg;
        ind_next     = ind_reg;
        if (relay == fb_reg) begin
            // contact is normally closed: open while supply is charged
            if (fb_cnt_reg == '0) begin
                fb_cnt_next = relay ? W'(FB_OPEN_CYC - IND_CLEAR_CYC - 1)
                                    : W'(FB_CLOSE_CYC - 1);
            end else if (fb_cnt_reg == W'(1)) begin
                fb_cnt_next = '0;
                fb_next     = ~relay;
            end else begin
                fb_cnt_next = fb_cnt_reg - 1'b1;
            end
        end else begin
            fb_cnt_next = '0;
        end
        if (fb_reg != ind_reg) begin
            if (ind_cnt_reg == '0) begin
                ind_cnt_next = fb_reg ? W'(IND_SET_CYC - 1)
                                      : W'(IND_CLEAR_CYC - 1);
            end else if (ind_cnt_reg == W'(1)) begin
                ind_cnt_next = '0;
                ind_next     = fb_reg;
            end else begin
                ind_cnt_next = ind_cnt_reg - 1'b1;
            end
        end else begin
            ind_cnt_next = '0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fb_cnt_reg  <= '0;
            fb_reg      <= 1'b1;
            ind_cnt_reg <= '0;
            ind_reg     <= 1'b1;
        end else begin
            fb_cnt_reg  <= fb_cnt_next;
            fb_reg      <= fb_next;
            ind_cnt_reg <= ind_cnt_next;
            ind_reg     <= ind_next;
        end
    end

    assign link.feedback_closed = fb_reg;
    assign link.sto_indicator   = ind_reg;
    assign speed_setpoint       = spd_reg;
    assign stage_enable         = stage_reg;
    assign brake_release        = brake_reg;
endmodule
`default_nettype wire

// ### sto_safety_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// superordinate safety controller end
module sto_safety_ctrl #(
    parameter int unsigned STAGE_LEAD_CYC = sto_pkg::STAGE_LEAD_CYC,
    parameter int unsigned CHECK_CYC      = sto_pkg::FB_CLOSE_CYC + sto_pkg::FB_OPEN_CYC
) (
    input  wire logic                        clk,
    input  wire logic                        reset,
    sto_if.safety                            link,
    input  wire logic [sto_pkg::ADDR_W-1:0]  addr,
    input  wire logic [31:0]                 wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic [31:0]                      rdata,
    input  wire logic                        estop_request,
    input  wire logic                        door_open,
    output logic                             power_contactor
);
    typedef enum logic [1:0] {CS_SAFE, CS_LEAD, CS_RUN, CS_STOP} sto_cstate_t;
    localparam int unsigned W = sto_pkg::CNT_W;

    initial begin
        if (STAGE_LEAD_CYC < 1 || CHECK_CYC < 2) $error("sto_safety_ctrl bad parameters");
    end

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_reg <= 4'hF;
            sync_reg <= 4'hF;
        end else begin
            meta_reg <= {door_open, estop_request, link.sto_indicator, link.feedback_closed};
            sync_reg <= meta_reg;
        end
    end

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    sto_cstate_t state_reg;
    sto_cstate_t state_next;
    logic        run_reg;
    logic        run_next;
    logic        stage_reg;
    logic        stage_next;
    logic        relay_reg;
    logic        relay_next;
    logic        en_reg;
    logic        en_next;
    logic        fault_reg;
    logic        fault_next;
    logic        adv_reg;
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic [W-1:0] chk_reg;
    logic [W-1:0] chk_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        kill;

    // both safety requests drop both paths at once and block restart
    assign kill = sync_reg[2] | sync_reg[3] | fault_reg;

    always_comb begin
        state_next = state_reg;
        run_next   = run_reg;
        stage_next = stage_reg;
        relay_next = relay_reg;
        en_next    = en_reg;
        fault_next = fault_reg;
        cnt_next   = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        chk_next   = chk_reg;
        rdata_next = 32'h0000_0000;
        if (wr && addr == sto_pkg::REG_CTRL) run_next = wdata[sto_pkg::CTRL_RUN_BIT];
        if (rd && addr == sto_pkg::REG_STATUS) begin
            rdata_next[sto_pkg::ST_FAULT_BIT]   = fault_reg;
            rdata_next[sto_pkg::ST_FB_BIT]      = sync_reg[0];
            rdata_next[sto_pkg::ST_STAGE_BIT]   = stage_reg;
            rdata_next[sto_pkg::ST_RELAY_BIT]   = relay_reg;
            rdata_next[sto_pkg::ST_STOPPED_BIT] = (state_reg == CS_SAFE);
            rdata_next[sto_pkg::ST_RUN_BIT]     = run_reg;
        end else if (rd && addr == sto_pkg::REG_CTRL) begin
            rdata_next[sto_pkg::CTRL_RUN_BIT] = run_reg;
        end
        // plausibility: feedback must become the inverse of relay state within the window
        if (relay_reg == sync_reg[0]) begin
            if (chk_reg == W'(CHECK_CYC)) fault_next = 1'b1;
            else chk_next = chk_reg + 1'b1;
        end else begin
            chk_next = '0;
        end
        case (state_reg)
            CS_SAFE: begin
                if (run_reg && !kill) begin
                    relay_next = 1'b1;
                    stage_next = 1'b1;
                    cnt_next   = W'(STAGE_LEAD_CYC);
                    state_next = CS_LEAD;
                end
            end
            CS_LEAD: begin
                if (cnt_reg == '0 && !sync_reg[0]) begin
                    en_next    = 1'b1;
                    state_next = CS_RUN;
                end
            end
            CS_RUN: begin
                if (!run_reg) begin
                    en_next    = 1'b0;
                    state_next = CS_STOP;
                end
            end
            CS_STOP: begin
                // software writes the advance register once the ramp and drop-out are over
                if (adv_reg) begin
                    relay_next = 1'b0;
                    stage_next = 1'b0;
                    state_next = CS_SAFE;
                end
            end
            default: state_next = CS_SAFE;
        endcase
        if (kill) begin
            relay_next = 1'b0;
            stage_next = 1'b0;
            en_next    = 1'b0;
            run_next   = 1'b0;
            state_next = CS_SAFE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= CS_SAFE;
            run_reg   <= 1'b0;
            stage_reg <= 1'b0;
            relay_reg <= 1'b0;
            en_reg    <= 1'b0;
            fault_reg <= 1'b0;
            adv_reg   <= 1'b0;
            cnt_reg   <= '0;
            chk_reg   <= '0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            run_reg   <= run_next;
            stage_reg <= stage_next;
            relay_reg <= relay_next;
            en_reg    <= en_next;
            fault_reg <= fault_next;
            adv_reg   <= wr && addr == sto_pkg::REG_ADVANCE;
            cnt_reg   <= cnt_next;
            chk_reg   <= chk_next;
            rdata_reg <= rdata_next;
        end
    end

    assign link.controller_enable_input  = en_reg;
    assign link.power_stage_enable_input = stage_reg;
    assign link.relay_trigger            = relay_reg;
    assign rdata                         = rdata_reg;
    assign power_contactor               = ~fault_reg;
endmodule
`default_nettype wire

// ### sto_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sto_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire logic controller_enable_input,
    input wire logic power_stage_enable_input,
    input wire logic relay_trigger,
    input wire logic feedback_closed,
    input wire logic sto_indicator
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // windows assume the shortened bench timers: close 40, open 20, clear 5, set 10
    fb_close_late_a: assert property ($fell(relay_trigger) && !feedback_closed |-> ##[30:60] feedback_closed)
        else $error("feedback contact did not close in time");
    fb_close_early_a: assert property ($fell(relay_trigger) && !feedback_closed |=> !feedback_closed[*8])
        else $error("feedback contact closed too early");
    ind_set_a: assert property ($rose(feedback_closed) |-> ##[1:16] sto_indicator)
        else $error("indicator late after contact closed");
    ind_cause_a: assert property ($rose(sto_indicator) |-> feedback_closed)
        else $error("indicator shown with contact open");
    fb_open_a: assert property ($rose(relay_trigger) && feedback_closed |-> ##[1:30] !feedback_closed)
        else $error("feedback contact did not open in time");
    ind_clear_a: assert property ($fell(feedback_closed) |-> ##[1:10] !sto_indicator)
        else $error("indicator not cleared after contact opened");
    stage_lead_a: assert property ($rose(controller_enable_input) |->
        $past(power_stage_enable_input, 3) && relay_trigger && !feedback_closed)
        else $error("controller enable without stage lead");
    paths_off_a: assert property ($fell(relay_trigger) |->
        !power_stage_enable_input && !controller_enable_input)
        else $error("relay dropped while stage or enable still on");

    run_c: cover property ($rose(controller_enable_input));
    safe_c: cover property ($rose(sto_indicator));
    open_c: cover property ($fell(feedback_closed));
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        estop = 1'b0;
    logic        door = 1'b0;
    logic [15:0] cmd = 16'h03E8;
    logic [31:0] sdly = 32'h00000014;
    logic [31:0] ddly = 32'h0000001E;
    logic [31:0] dtim = 32'h00000028;
    logic [15:0] acc = 16'h0064;
    logic [15:0] dec = 16'h0032;
    logic [31:0] rdata;
    logic        pc;
    logic [15:0] spd;
    logic        stg;
    logic        brk;
    int          n_errors = 0;
    int          check_count = 0;
    int          n;
    always #5 clk = ~clk;
    sto_if lnk();
    wire logic cen = lnk.controller_enable_input;
    wire logic rly = lnk.relay_trigger;
    wire logic pse = lnk.power_stage_enable_input;
    sto_drive #(.FB_CLOSE_CYC(40), .FB_OPEN_CYC(20), .IND_CLEAR_CYC(5), .IND_SET_CYC(10))
    sto_drive_i (.clk(clk), .reset(reset), .link(lnk), .start_delay_cyc(sdly),
        .dropout_delay_cyc(ddly), .decel_time_cyc(dtim), .speed_command(cmd),
        .accel_step(acc), .decel_step(dec), .speed_setpoint(spd),
        .stage_enable(stg), .brake_release(brk));
    sto_safety_ctrl #(.STAGE_LEAD_CYC(3)) sto_safety_ctrl_i (.clk(clk),
        .reset(reset), .link(lnk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .estop_request(estop), .door_open(door), .power_contactor(pc));
    sto_assertions sto_assertions_i (.clk(clk), .reset(reset), .controller_enable_input(cen),
        .power_stage_enable_input(pse), .relay_trigger(rly),
        .feedback_closed(lnk.feedback_closed), .sto_indicator(lnk.sto_indicator));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & m, e);
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return cen === 1'b1;
            1: return lnk.feedback_closed === 1'b1;
            2: return lnk.sto_indicator === 1'b1;
            3: return stg === 1'b0;
            4: return spd === cmd;
            5: return spd !== 16'h0000;
            6: return stg === 1'b1;
            default: return spd === 16'h0000;
        endcase
    endfunction
    // bounded poll; leaves one more than the cycles waited in n so ramps and delays can be measured
    task automatic wt(input int s);
        for (n = 1; n < 600 && !sig(s); n++) begin
            @(posedge clk);
            #1;
        end
        if (!sig(s)) chk(32'h0, 32'h1);
    endtask
    task automatic trip(input logic e, input logic d);
        wr_reg(sto_pkg::REG_CTRL, 32'h1);
        wt(4);
        chk(brk, 1'b1);
        estop <= e;
        door <= d;
        repeat (6) @(posedge clk);
        #1;
        chk({rly, pse, cen, brk, spd}, 20'h0);
    endtask
    task results;
        if (n_errors == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        #1;
        chk({lnk.feedback_closed, lnk.sto_indicator, pc, rly}, 4'b1110);
        rd_reg(4'h7, 32'hFFFFFFFF, 32'h0);
        wr_reg(sto_pkg::REG_CTRL, 32'h1);
        wt(0);
        chk({rly, pse}, 2'b11);
        wt(6);
        chk({brk, spd}, 17'h10000);
        wt(5);
        chk(n >= 20, 1'b1);
        wt(4);
        chk(n >= 9 && n <= 11, 1'b1);
        rd_reg(sto_pkg::REG_STATUS, 32'h2F, 32'h2C);
        wr_reg(sto_pkg::REG_CTRL, 32'h0);
        wt(7);
        chk(n >= 19 && n <= 26, 1'b1);
        chk({stg, rly}, 2'b11);
        wt(3);
        chk(n >= 28 && n <= 34, 1'b1);
        chk(brk, 1'b0);
        wr_reg(sto_pkg::REG_ADVANCE, 32'h1);
        wt(1);
        wt(2);
        rd_reg(sto_pkg::REG_STATUS, 32'h0B, 32'h02);
        // second run: zero delays, tiny brake deadline applies the brake during the slow ramp-down
        @(posedge clk);
        sdly <= 32'h00000000;
        ddly <= 32'h00000000;
        dtim <= 32'h00000002;
        acc <= 16'h00C8;
        dec <= 16'h0019;
        cmd <= 16'h0320;
        wr_reg(sto_pkg::REG_CTRL, 32'h1);
        wt(6);
        chk(brk, 1'b1);
        wt(5);
        chk(n <= 3, 1'b1);
        wt(4);
        wr_reg(sto_pkg::REG_CTRL, 32'h0);
        repeat (10) @(posedge clk);
        #1;
        chk({brk, spd != 16'h0000}, 2'b01);
        wt(3);
        wr_reg(sto_pkg::REG_ADVANCE, 32'h1);
        wt(1);
        wt(2);
        trip(1'b1, 1'b0);
        wr_reg(sto_pkg::REG_CTRL, 32'h0);
        estop <= 1'b0;
        wt(2);
        trip(1'b0, 1'b1);
        wr_reg(sto_pkg::REG_CTRL, 32'h0);
        wr_reg(sto_pkg::REG_CTRL, 32'h1);
        repeat (30) @(posedge clk);
        chk({cen, rly, pc}, 3'b001);
        results();
    end
    // whole sequence is a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule
`default_nettype wire
